// ===== hw/eewh_defs.vh
`ifndef EEWH_DEFS_VH
`define EEWH_DEFS_VH
// device address byte layout
`define EEWH_DEV_TYPE        4'ha
`define EEWH_RW_WRITE        1'b0
// serial clock timing: quarter period in reference clocks (125 MHz / 4 / 125 = 250 kHz)
`define EEWH_QTR_CNT         8'h7c
`define EEWH_QTR_W           8
// bit counts
`define EEWH_BIT_LAST        4'h7
`define EEWH_RECOVER_PULSES  4'h9
// page geometry
`define EEWH_PAGE_LAST       8'hff
`define EEWH_ZERO8           8'h00
`define EEWH_PAGE_BYTES      9'h100
// word address bytes sent after the device address byte
`define EEWH_HDR_BYTES       2'h2
`endif

// ===== hw/eewh_qtr_tick.v
`timescale 1ns/1ps
`default_nettype none
`include "eewh_defs.vh"
// quarter-bit tick generator; restarts whenever clear is high
module eewh_qtr_tick
(
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // control
   input  wire        clear_i,
   output reg         tick_o
);
   reg  [`EEWH_QTR_W-1:0] cnt_ff;

   // free count between ticks
   always @(posedge ref_clk_i)
   begin
      if (rst_i || clear_i)
      begin
         cnt_ff <= `EEWH_ZERO8;
         tick_o <= 1'b0;
      end
      else if (cnt_ff == `EEWH_QTR_CNT)
      begin
         cnt_ff <= `EEWH_ZERO8;
         tick_o <= 1'b1;
      end
      else
      begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule // eewh_qtr_tick
`default_nettype wire

// ===== hw/eewh_host.v
`timescale 1ns/1ps
`default_nettype none
`include "eewh_defs.vh"
module eewh_host
(
   // clock and reset
   input  wire        ref_clk_i,
   input  wire        rst_i,
   // command port
   input  wire        wr_start_i,
   input  wire        recover_i,
   input  wire        client_address_strap_i,
   input  wire [17:0] byte_addr_i,
   input  wire [8:0]  byte_count_i,
   // data stream in
   input  wire [7:0]  wr_data_i,
   input  wire        wr_valid_i,
   output reg         wr_ready_o,
   // status
   output reg         busy_o,
   output reg         done_o,
   output reg         nack_o,
   // two-wire pins
   output reg         scl_o,
   output reg         scl_oe_o,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o
);
   localparam [6:0] ST_IDLE  = 7'h01;
   localparam [6:0] ST_START = 7'h02;
   localparam [6:0] ST_BYTE  = 7'h04;
   localparam [6:0] ST_ACK   = 7'h08;
   localparam [6:0] ST_STOP  = 7'h10;
   localparam [6:0] ST_REC   = 7'h20;
   localparam [6:0] ST_LOAD  = 7'h40;

   reg  [6:0]  state_ff;
   reg  [1:0]  phase_ff;       // quarter within a bit: 0 low,1 low,2 high,3 high
   reg  [3:0]  bit_ff;
   reg  [7:0]  shift_ff;
   reg  [1:0]  hdr_ff;         // header bytes still to send
   reg  [8:0]  left_ff;        // data bytes still to send
   reg  [17:0] addr_ff;
   reg         strap_ff;
   reg         ack_bad_ff;
   reg         rec_start_ff;   // recovery ends with start+stop
   wire        tick;
   wire        clr = (state_ff == ST_IDLE);

   eewh_qtr_tick u_tick
   (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .clear_i   (clr),
      .tick_o    (tick)
   );

   // address byte: type, strap, top address bits, direction
   wire [7:0] dev_byte = {`EEWH_DEV_TYPE, strap_ff, addr_ff[17:16], `EEWH_RW_WRITE};

   // main sequencer; all pin changes happen on quarter ticks
   always @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         state_ff     <= ST_IDLE;
         phase_ff     <= 2'h0;
         bit_ff       <= 4'h0;
         shift_ff     <= `EEWH_ZERO8;
         hdr_ff       <= 2'h0;
         left_ff      <= 9'h000;
         addr_ff      <= 18'h00000;
         strap_ff     <= 1'b0;
         ack_bad_ff   <= 1'b0;
         rec_start_ff <= 1'b0;
         wr_ready_o   <= 1'b0;
         busy_o       <= 1'b0;
         done_o       <= 1'b0;
         nack_o       <= 1'b0;
         scl_o        <= 1'b1;
         scl_oe_o     <= 1'b1;
         sda_o        <= 1'b1;
         sda_oe_o     <= 1'b0;
      end
      else
      begin
         done_o     <= 1'b0;
         wr_ready_o <= 1'b0;
         case (state_ff)
            ST_IDLE:
            begin
               phase_ff <= 2'h0;
               sda_oe_o <= 1'b0;
               scl_o    <= 1'b1;
               if (recover_i)
               begin
                  busy_o   <= 1'b1;
                  bit_ff   <= 4'h0;
                  state_ff <= ST_REC;
               end
               else if (wr_start_i && byte_count_i != 9'h000)
               begin
                  busy_o     <= 1'b1;
                  nack_o     <= 1'b0;
                  ack_bad_ff <= 1'b0;
                  addr_ff    <= byte_addr_i;
                  strap_ff   <= client_address_strap_i;
                  // cap at one page; more would wrap over loaded data
                  left_ff    <= (byte_count_i > `EEWH_PAGE_BYTES) ? `EEWH_PAGE_BYTES
                                                                : byte_count_i;
                  hdr_ff     <= `EEWH_HDR_BYTES;
                  state_ff   <= ST_START;
               end
            end
            ST_START:
            if (tick)
            begin
               phase_ff <= phase_ff + 2'h1;
               // data falls while clock high, then clock falls
               if (phase_ff == 2'h0)
               begin
                  sda_oe_o <= 1'b1;
                  sda_o    <= 1'b0;
               end
               else if (phase_ff == 2'h1)
               begin
                  scl_o    <= 1'b0;
                  shift_ff <= dev_byte;
                  bit_ff   <= 4'h0;
                  phase_ff <= 2'h0;
                  state_ff <= ST_BYTE;
               end
            end
            ST_BYTE:
            if (tick)
            begin
               phase_ff <= phase_ff + 2'h1;
               case (phase_ff)
                  2'h0:
                  begin
                     sda_oe_o <= ~shift_ff[7]; // change only while clock low
                     sda_o    <= 1'b0;
                  end
                  2'h1: scl_o <= 1'b1;
                  2'h2: scl_o <= 1'b1;
                  default:
                  begin
                     scl_o    <= 1'b0;
                     shift_ff <= {shift_ff[6:0], 1'b0};
                     bit_ff   <= bit_ff + 4'h1;
                     if (bit_ff == `EEWH_BIT_LAST)
                     begin
                        sda_oe_o <= 1'b0;      // release after eighth fall
                        state_ff <= ST_ACK;
                     end
                  end
               endcase
            end
            ST_ACK:
            if (tick)
            begin
               phase_ff <= phase_ff + 2'h1;
               case (phase_ff)
                  2'h0: sda_oe_o <= 1'b0;
                  2'h1: scl_o <= 1'b1;
                  2'h2: ack_bad_ff <= sda_i;   // device must hold low whole high phase
                  default:
                  begin
                     scl_o  <= 1'b0;           // device releases after this fall
                     bit_ff <= 4'h0;
                     // only look at data while the ninth pulse is still high; a stall
                     // re-enters here with the clock low and the device released
                     if (ack_bad_ff || (scl_o && sda_i))
                     begin
                        nack_o   <= 1'b1;      // no programming will follow
                        state_ff <= ST_STOP;   // data is driven low, then released with clock high for the stop
                     end
                     else if (hdr_ff != 2'h0)
                     begin
                        hdr_ff   <= hdr_ff - 2'h1;
                        // high word address byte first, then low
                        shift_ff <= (hdr_ff == `EEWH_HDR_BYTES) ? addr_ff[15:8] : addr_ff[7:0];
                        state_ff <= ST_BYTE;
                     end
                     else if (left_ff != 9'h000 && wr_valid_i)
                     begin
                        state_ff <= ST_LOAD;
                     end
                     else if (left_ff != 9'h000)
                        phase_ff <= 2'h3;      // stall with clock low until data arrives
                     else
                        state_ff <= ST_STOP;   // final stop launches programming
                  end
               endcase
            end
            ST_LOAD:
            begin
               wr_ready_o <= 1'b1;
               shift_ff   <= wr_data_i;
               left_ff    <= left_ff - 9'h001;
               // mirror the device's in-page increment
               addr_ff    <= {addr_ff[17:8], addr_ff[7:0] + 8'h01};
               phase_ff   <= 2'h0;
               state_ff   <= ST_BYTE;
            end
            ST_STOP:
            if (tick)
            begin
               phase_ff <= phase_ff + 2'h1;
               case (phase_ff)
                  2'h0:
                  begin
                     sda_oe_o <= 1'b1;
                     sda_o    <= 1'b0;
                  end
                  2'h1: scl_o <= 1'b1;
                  2'h2: sda_oe_o <= 1'b0;     // data rises with clock high
                  default:
                  begin
                     busy_o   <= 1'b0;
                     done_o   <= 1'b1;
                     state_ff <= ST_IDLE;
                  end
               endcase
            end
            ST_REC:
            if (tick)
            begin
               phase_ff <= phase_ff + 2'h1;
               case (phase_ff)
                  2'h0: scl_o <= 1'b0;
                  2'h1: scl_o <= 1'b0;
                  2'h2: scl_o <= 1'b1;
                  default:
                  begin
                     bit_ff <= bit_ff + 4'h1;
                     // stop pulsing once data is free or nine pulses spent
                     if (sda_i || bit_ff == `EEWH_RECOVER_PULSES - 4'h1)
                     begin
                        rec_start_ff <= 1'b1;
                        state_ff     <= ST_START;
                        hdr_ff       <= 2'h0;
                        left_ff      <= 9'h000;
                        nack_o       <= ~sda_i;
                     end
                  end
               endcase
            end
            default: state_ff <= ST_IDLE;
         endcase
         // after a recovery the start is followed straight by a stop
         if (rec_start_ff && state_ff == ST_START && tick && phase_ff == 2'h1)
         begin
            rec_start_ff <= 1'b0;
            state_ff     <= ST_STOP;
         end
      end
   end
endmodule // eewh_host
`default_nettype wire

// ===== testbench/eewh_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// pin-level checks of the host; one clock domain only
module eewh_host_monitor
(
   // clock and reset
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   // command and status
   input wire logic       wr_start_i,
   input wire logic       recover_i,
   input wire logic [8:0] byte_count_i,
   input wire logic       wr_valid_i,
   input wire logic       wr_ready_o,
   input wire logic       busy_o,
   input wire logic       done_o,
   input wire logic       nack_o,
   // bus pins
   input wire logic       scl_o,
   input wire logic       scl_oe_o,
   input wire logic       sda_o,
   input wire logic       sda_oe_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // request taken in idle
   sequence s_take;
      !busy_o && (recover_i || (wr_start_i && byte_count_i != 9'h000));
   endsequence
   // data released while clock high
   sequence s_stop;
      $fell(sda_oe_o) && scl_o && busy_o;
   endsequence
   take_busy_a: assert property (s_take |=> busy_o)
      else $error("request not taken");
   nack_clear_a: assert property (!busy_o && wr_start_i && byte_count_i != 9'h000 && !recover_i
      |=> !nack_o) else $error("nack not cleared");
   pin_drive_a: assert property (scl_oe_o && !(sda_oe_o && sda_o))
      else $error("bad pin drive");
   idle_bus_a: assert property (!busy_o |-> scl_o && !sda_oe_o)
      else $error("bus not idle");
   start_cond_a: assert property ($rose(busy_o) && !$past(recover_i) |-> ##[1:200] ($rose(sda_oe_o) && scl_o))
      else $error("no start");
   stop_done_a: assert property (s_stop |-> ##[0:500] done_o)
      else $error("stop without done");
   done_pulse_a: assert property (done_o |=> !done_o && !busy_o)
      else $error("done not a pulse");
   ready_pulse_a: assert property (wr_ready_o |-> busy_o && wr_valid_i ##1 !wr_ready_o)
      else $error("bad ready");
   scl_high_a: assert property ($rose(scl_o) |=> scl_o[*8])
      else $error("clock pulse too short");
endmodule // eewh_host_monitor
bind eewh_host eewh_host_monitor eewh_host_monitor_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
   .wr_start_i(wr_start_i), .recover_i(recover_i), .byte_count_i(byte_count_i),
   .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .busy_o(busy_o), .done_o(done_o),
   .nack_o(nack_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
`default_nettype wire

// ===== testbench/eewh_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural client memory, write direction only
module eewh_dev_model
#(parameter logic STRAP = 1'b1)
(
   // bus
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output var  logic        pull_o,
   // observation
   output var  logic [17:0] last_addr_o,
   output var  logic [7:0]  last_data_o,
   output var  int          prog_cnt_o
);
   logic [17:0] addr;
   logic [7:0]  sh;
   logic        act = 1'b0, sel = 1'b0, prog = 1'b0;
   int          bits = 0, nb = 0;
   initial {pull_o, prog_cnt_o} = 0;
   // start wakes the device, ignored while programming
   always @(negedge sda_i)
      if (scl_i === 1'b1 && !prog)
         {act, sel, bits, nb} = {2'b10, 32'h0, 32'h0};
   // stop programs only after an acked data byte
   always @(posedge sda_i)
      if (scl_i === 1'b1 && act)
      begin
         act = 1'b0;
         prog = nb > 3;
         prog_cnt_o += int'(prog);
         #50000 prog = 1'b0; // shortened programming_cycle_time
      end
   // sample on rising clock, msb first
   always @(posedge scl_i)
      if (act && bits < 8)
         {sh, bits} = {sh[6:0], sda_i, bits + 1};
   // ack after eighth fall, release after ninth
   always @(negedge scl_i)
      if (act && bits == 9)
         {pull_o, bits, act} = {1'b0, 32'h0, sel};
      else if (act && bits == 8)
      begin
         if (nb == 0)
            {sel, addr[17:16]} = {sh[7:4] == 4'ha && sh[3] == STRAP && !sh[0], sh[2:1]};
         else if (nb < 3)
            addr = (nb == 1) ? {addr[17:16], sh, addr[7:0]} : {addr[17:8], sh};
         else // in-page increment only
            {last_addr_o, last_data_o, addr[7:0]} = {addr, sh, addr[7:0] + 8'h01};
         {pull_o, bits, nb} = {sel, 32'd9, nb + 1};
      end
endmodule // eewh_dev_model
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        ref_clk_i = 1'b0, rst_i = 1'b1, wr_start_i = 1'b0, recover_i = 1'b0;
   logic        strap = 1'b1, wr_valid_i = 1'b1, stuck = 1'b0;
   logic [17:0] addr = 18'h0_0000, l_addr;
   logic [8:0]  cnt = 9'h001;
   logic [7:0]  wr_data_i, l_data;
   wire         wr_ready_o, busy_o, done_o, nack_o, scl_o, scl_oe_o, sda_o, sda_oe_o, pull;
   int          mismatches = 0, tests_run = 0, cyc = 0, di = 0, progs;
   // open-drain data with pull-up; clock push-pull
   wire scl = scl_oe_o ? scl_o : 1'b1;
   wire sda = !((sda_oe_o && !sda_o) || pull || stuck);
   always #4 ref_clk_i = !ref_clk_i;
   always @* wr_data_i = 8'h3c + 8'h11 * di[7:0];
   // next byte once the host takes one
   always @(posedge ref_clk_i)
   begin
      if (wr_ready_o) di <= di + 1;
      cyc <= cyc + 1;
      if (cyc == 95000) begin mismatches++; wrap_up; end
   end
   eewh_host eewh_host_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_start_i(wr_start_i),
      .recover_i(recover_i), .client_address_strap_i(strap), .byte_addr_i(addr),
      .byte_count_i(cnt), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
      .wr_ready_o(wr_ready_o), .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o),
      .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o));
   eewh_dev_model eewh_dev_model_i (.scl_i(scl), .sda_i(sda), .pull_o(pull),
      .last_addr_o(l_addr), .last_data_o(l_data), .prog_cnt_o(progs));
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one request, then bounded wait for done
   task run(input logic r);
      int n;
      n = 0;
      @(posedge ref_clk_i) #1 {recover_i, wr_start_i} = {r, !r};
      @(posedge ref_clk_i) #1 {recover_i, wr_start_i} = 2'b00;
      while (done_o !== 1'b1 && n < 40000) @(posedge ref_clk_i) #1 n++;
      check(n < 40000, 1);
   endtask
   task t_byte;
      {addr, cnt, di} = {18'h2_3456, 9'h001, 32'h0};
      run(0);
      check(nack_o, 0);
      check(l_addr, 18'h2_3456);
      check(l_data, 8'h3c);
      check(progs, 1);
   endtask
   // page end boundary, then a request while programming
   task t_page;
      repeat (6500) @(posedge ref_clk_i);
      #1 {addr, cnt, di, wr_valid_i} = {18'h1_02fe, 9'h002, 32'h0, 1'b0};
      // data arrives late: host must stall with the clock low, not report a nack
      fork
         run(0);
         begin repeat (16000) @(posedge ref_clk_i); #1 wr_valid_i = 1'b1; end
      join
      check(nack_o, 0);
      check(l_addr, 18'h1_02ff);
      check(l_data, 8'h4d);
      check(progs, 2);
      run(0);
      check(nack_o, 1);
      check(progs, 2);
   endtask
   task t_strap;
      repeat (6500) @(posedge ref_clk_i);
      #1 strap = 1'b0;
      run(0);
      check(nack_o, 1);
      check(progs, 2);
      strap = 1'b1;
   endtask
   // data held low, freed at the third clock fall, then for good
   task t_recover;
      stuck = 1'b1;
      fork
         run(1);
         begin repeat (3) @(negedge scl); #1 stuck = 1'b0; end
      join
      check(nack_o, 0);
      stuck = 1'b1;
      run(1);
      check(nack_o, 1);
      stuck = 1'b0;
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      t_byte;
      t_page;
      t_strap;
      t_recover;
      wrap_up;
   end
endmodule // tb
`default_nettype wire
